// ### sri_pkg.sv
package sri_pkg;

  // frame layout, shifted msb first: chip address, register number, data
  localparam int unsigned FRAME_BITS = 24;   // clocks in a write frame
  localparam int unsigned READ_BITS  = 48;   // clocks in a read frame
  localparam int unsigned CHIP_W     = 3;    // chip address width
  localparam int unsigned REGNUM_W   = 5;    // register number width
  localparam int unsigned DATA_W     = 16;   // register data width
  localparam int unsigned CNT_W      = 6;    // pulse counter, saturates
  localparam int unsigned NUM_REGS   = 7;    // stored control registers

  // field positions inside the 24-bit shift word
  localparam int unsigned CHIP_MSB   = 23;
  localparam int unsigned CHIP_LSB   = 21;
  localparam int unsigned REGN_MSB   = 20;
  localparam int unsigned REGN_LSB   = 16;

  // readback window: pulses 25..40 carry data bit 15..0
  localparam logic [CNT_W-1:0] RD_FIRST = 6'h19;
  localparam logic [CNT_W-1:0] RD_LAST  = 6'h28;
  localparam logic [CNT_W-1:0] CNT_WR   = 6'h18;  // exact write length
  localparam logic [CNT_W-1:0] CNT_MAX  = 6'h3F;

  // host limit on the serial clock, and its period in system cycles
  localparam int unsigned SCLK_MAX_HZ = 10_000_000;
  localparam int unsigned SYS_HZ      = 125_000_000;
  localparam int unsigned SCLK_MIN_CYC = SYS_HZ / SCLK_MAX_HZ;

  // register numbers
  localparam logic [REGNUM_W-1:0] OFF_BLOCK_ENABLES = 5'h01;
  localparam logic [REGNUM_W-1:0] OFF_INPUT_GAIN    = 5'h03;
  localparam logic [REGNUM_W-1:0] OFF_AMP_BIAS      = 5'h04;
  localparam logic [REGNUM_W-1:0] OFF_MIXER_I       = 5'h05;
  localparam logic [REGNUM_W-1:0] OFF_MIXER_Q       = 5'h06;
  localparam logic [REGNUM_W-1:0] OFF_READ_POINTER  = 5'h07;
  localparam logic [REGNUM_W-1:0] OFF_PHASE_I       = 5'h08;
  localparam logic [REGNUM_W-1:0] OFF_PHASE_Q       = 5'h09;

  // reset words
  localparam logic [DATA_W-1:0] RST_BLOCK_ENABLES = 16'hD9FA;
  localparam logic [DATA_W-1:0] RST_INPUT_GAIN    = 16'h0000;
  localparam logic [DATA_W-1:0] RST_AMP_BIAS      = 16'h0FF2;
  localparam logic [DATA_W-1:0] RST_MIXER_I       = 16'h2A00;
  localparam logic [DATA_W-1:0] RST_MIXER_Q       = 16'hF000;
  localparam logic [DATA_W-1:0] RST_PHASE         = 16'hF000;

  // per-slot tables for the register array
  localparam logic [NUM_REGS-1:0][REGNUM_W-1:0] SLOT_OFF = {
    OFF_PHASE_Q, OFF_PHASE_I, OFF_MIXER_Q, OFF_MIXER_I,
    OFF_AMP_BIAS, OFF_INPUT_GAIN, OFF_BLOCK_ENABLES};
  localparam logic [NUM_REGS-1:0][DATA_W-1:0] SLOT_RST = {
    RST_PHASE, RST_PHASE, RST_MIXER_Q, RST_MIXER_I,
    RST_AMP_BIAS, RST_INPUT_GAIN, RST_BLOCK_ENABLES};

  // slot indices
  localparam int unsigned SL_EN  = 0;
  localparam int unsigned SL_GN  = 1;
  localparam int unsigned SL_AB  = 2;
  localparam int unsigned SL_MI  = 3;
  localparam int unsigned SL_MQ  = 4;
  localparam int unsigned SL_PI  = 5;
  localparam int unsigned SL_PQ  = 6;

  // field positions in the stored words
  localparam int unsigned B_LOGIF = 12;
  localparam int unsigned B_D2SE  = 11;
  localparam int unsigned B_CMBUF = 9;
  localparam int unsigned B_LOGD  = 7;
  localparam int unsigned B_SQD   = 6;
  localparam int unsigned B_ENVN  = 5;
  localparam int unsigned B_VGA   = 4;
  localparam int unsigned B_IRM   = 3;
  localparam int unsigned B_IQ    = 2;
  localparam int unsigned B_DGA   = 1;
  localparam int unsigned B_LPF   = 0;
  localparam int unsigned GAIN_MSB = 14;
  localparam int unsigned GAIN_LSB = 9;
  localparam int unsigned CUR_MSB  = 8;
  localparam int unsigned CUR_LSB  = 7;
  localparam int unsigned ENV_MSB  = 6;
  localparam int unsigned ENV_LSB  = 2;
  localparam int unsigned ATT_MSB  = 1;
  localparam int unsigned ATT_LSB  = 0;
  localparam int unsigned B_SIDEB  = 11;
  localparam int unsigned B_OPOL   = 8;
  localparam int unsigned OFS_MSB  = 7;
  localparam int unsigned OFS_LSB  = 0;
  localparam int unsigned PH_MSB   = 8;
  localparam int unsigned PH_LSB   = 0;

  // frame sequencer, gray along idle -> shift -> load; load -> idle flips both bits
  typedef enum logic [1:0] {
    SRI_IDLE  = 2'b00,
    SRI_SHIFT = 2'b01,
    SRI_LOAD  = 2'b11
  } sri_state_e;

endpackage : sri_pkg

// ### sri_reg_if.sv
// write strobe and readback path between the frame engine and the array
interface sri_reg_if;
  logic                                          wr_stb;   // one-cycle pulse
  logic [sri_pkg::REGNUM_W-1:0]                  wr_addr;  // target number
  logic [sri_pkg::DATA_W-1:0]                    wr_data;  // whole new word
  logic [sri_pkg::REGNUM_W-1:0]                  rd_addr;  // read pointer
  logic [sri_pkg::DATA_W-1:0]                    rd_data;  // selected word
  logic [sri_pkg::NUM_REGS-1:0][sri_pkg::DATA_W-1:0] words; // all stored words

  modport engine (output wr_stb, output wr_addr, output wr_data,
                  output rd_addr, input rd_data, input words);
  modport array  (input wr_stb, input wr_addr, input wr_data,
                  input rd_addr, output rd_data, output words);
endinterface : sri_reg_if

// ### sri_sync.sv
// two-stage synchroniser for pins from outside the system clock
module sri_sync #(
  parameter int unsigned W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         sys_rst,
  // raw pins and their safe copies
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  genvar gi;
  generate
    for (gi = 0; gi < W; gi++)
    begin : g_bit
      logic meta_ff;  // first stage, read only by the second
      logic safe_ff;  // second stage, free to use

      // one chain per pin; skew between pins is at most one cycle
      always_ff @(posedge clk_sys or posedge sys_rst)
      begin
        if (sys_rst)
        begin
          meta_ff <= RST_VAL[gi];
          safe_ff <= RST_VAL[gi];
        end
        else
        begin
          meta_ff <= async_in[gi];
          safe_ff <= meta_ff;
        end
      end

      assign sync_out[gi] = safe_ff;
    end
  endgenerate

endmodule : sri_sync

// ### sri_regs.sv
// seven 16-bit control words, written whole, read through the pointer
module sri_regs (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  // engine side
  sri_reg_if.array  rif
);

  genvar gi;
  generate
    for (gi = 0; gi < sri_pkg::NUM_REGS; gi++)
    begin : g_slot
      logic [sri_pkg::DATA_W-1:0] word_ff;  // stored word incl. reserved bits

      // a matching strobe replaces every bit at once
      always_ff @(posedge clk_sys or posedge sys_rst)
      begin
        if (sys_rst)
          word_ff <= sri_pkg::SLOT_RST[gi];  // reset word per slot
        else if (rif.wr_stb && rif.wr_addr == sri_pkg::SLOT_OFF[gi])
          word_ff <= rif.wr_data;
      end

      assign rif.words[gi] = word_ff;
    end
  endgenerate

  // readback mux; unmapped numbers and the pointer itself read zero
  always_comb
  begin
    rif.rd_data = '0;
    for (int i = 0; i < sri_pkg::NUM_REGS; i++)
    begin
      if (rif.rd_addr == sri_pkg::SLOT_OFF[i])
        rif.rd_data = rif.words[i];
    end
  end

endmodule : sri_regs

// ### sri_top.sv
module sri_top #(
  // chip address this device answers to; arbitrary default
  parameter logic [sri_pkg::CHIP_W-1:0] CHIP_ADDR = 3'h0
) (
  // system clock and reset
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  // serial port pins, asynchronous to clk_sys
  input  wire logic       serial_clk,
  input  wire logic       serial_select_n,
  input  wire logic       serial_data_in,
  output logic            serial_data_out,
  // block enables, one means on, except envelope_detector_off where one means off
  output logic            if_log_detector_on,
  output logic            diff_to_single_on,
  output logic            common_mode_buf_on,
  output logic            log_detector_on,
  output logic            square_detector_on,
  output logic            envelope_detector_off,
  output logic            variable_gain_on,
  output logic            image_mixer_on,
  output logic            iq_lines_on,
  output logic            stepped_gain_on,
  output logic            lowpass_on,
  // factory diagnostic bits, passed out as stored
  output logic            diag_bit10,
  output logic            diag_bit8,
  // gain and bias
  output logic [5:0]      stepped_gain_word,
  output logic [1:0]      amplifier_current,
  output logic [4:0]      envelope_level,
  output logic [1:0]      attenuator_bias,
  // mixer trims
  output logic            sideband_select,
  output logic            i_offset_polarity,
  output logic [7:0]      i_offset_value,
  output logic            q_offset_polarity,
  output logic [7:0]      q_offset_value,
  output logic [8:0]      i_phase_trim,
  output logic [8:0]      q_phase_trim
);

  // register array link
  sri_reg_if rif ();

  // synchronised pins: clock, select, data
  logic [2:0]                        pins_sync;
  logic                              sclk_s;     // synced serial clock
  logic                              sel_n_s;    // synced select
  logic                              sdi_s;      // synced data in
  logic                              sclk_d_ff;  // previous serial clock
  logic                              sel_n_d_ff; // previous select
  logic                              sclk_rise;  // serial clock rising
  logic                              sel_fall;   // frame start
  logic                              sel_rise;   // frame end

  // frame engine state
  sri_pkg::sri_state_e               state_ff;
  sri_pkg::sri_state_e               nxt_state;
  logic [sri_pkg::FRAME_BITS-1:0]    shift_ff;   // last 24 bits taken
  logic [sri_pkg::CNT_W-1:0]         count_ff;   // pulses this frame
  logic [sri_pkg::CNT_W-1:0]         nxt_count;  // count after this pulse
  logic                              wr_stb_ff;  // one-cycle write strobe
  logic [sri_pkg::REGNUM_W-1:0]      wr_addr_ff; // latched register number
  logic [sri_pkg::DATA_W-1:0]        wr_data_ff; // latched data word
  logic [sri_pkg::REGNUM_W-1:0]      ptr_ff;     // read pointer
  logic                              sdo_ff;     // readback pin
  logic                              frame_ok;   // full write, our chip
  logic [3:0]                        rd_bit;     // bit index being sent

  // pins come from the host's domain; all three share one synchroniser.
  // the host limit keeps one serial period at or above a dozen system cycles,
  // so no edge is missed by this sampling
  sri_sync #(
    .W       (3),
    .RST_VAL (3'b010)
  ) u_sync (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .async_in ({serial_clk, serial_select_n, serial_data_in}),
    .sync_out (pins_sync)
  );

  assign sclk_s  = pins_sync[2];
  assign sel_n_s = pins_sync[1];
  assign sdi_s   = pins_sync[0];

  // edge history on the safe copies only
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sclk_d_ff  <= 1'b0;
      sel_n_d_ff <= 1'b1;  // idle select is high
    end
    else
    begin
      sclk_d_ff  <= sclk_s;
      sel_n_d_ff <= sel_n_s;
    end
  end

  assign sclk_rise = sclk_s & ~sclk_d_ff & ~sel_n_s;
  assign sel_fall  = ~sel_n_s & sel_n_d_ff;
  assign sel_rise  = sel_n_s & ~sel_n_d_ff;
  assign nxt_count = (count_ff == sri_pkg::CNT_MAX) ? count_ff
                   : count_ff + 6'h01;

  // a write needs exactly 24 pulses and our chip address
  assign frame_ok = (count_ff == sri_pkg::CNT_WR) &&
                    (shift_ff[sri_pkg::CHIP_MSB:sri_pkg::CHIP_LSB] == CHIP_ADDR);

  // frame sequencer
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      sri_pkg::SRI_IDLE:
      begin
        if (sel_fall)
          nxt_state = sri_pkg::SRI_SHIFT;
      end
      sri_pkg::SRI_SHIFT:
      begin
        if (sel_rise)
          nxt_state = sri_pkg::SRI_LOAD;
      end
      sri_pkg::SRI_LOAD:
        nxt_state = sri_pkg::SRI_IDLE;
      default:
        nxt_state = sri_pkg::SRI_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      state_ff <= sri_pkg::SRI_IDLE;
    else
      state_ff <= nxt_state;
  end

  // shifter: msb first, so the data lsb lands last
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      shift_ff <= '0;
    else if (sclk_rise && state_ff == sri_pkg::SRI_SHIFT)
      shift_ff <= {shift_ff[sri_pkg::FRAME_BITS-2:0], sdi_s};
  end

  // pulse counter, cleared at frame start, saturating for long frames
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      count_ff <= '0;
    else if (sel_fall)
      count_ff <= '0;
    else if (sclk_rise && state_ff == sri_pkg::SRI_SHIFT)
      count_ff <= nxt_count;
  end

  // write strobe on select rise; a 48-pulse read never stores
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wr_stb_ff  <= 1'b0;
      wr_addr_ff <= '0;
      wr_data_ff <= '0;
    end
    else
    begin
      wr_stb_ff <= 1'b0;
      if (state_ff == sri_pkg::SRI_SHIFT && sel_rise && frame_ok)
      begin
        wr_stb_ff  <= 1'b1;
        wr_addr_ff <= shift_ff[sri_pkg::REGN_MSB:sri_pkg::REGN_LSB];
        wr_data_ff <= shift_ff[sri_pkg::DATA_W-1:0];
      end
    end
  end

  // pointer takes the top five data bits; the host zeroes the rest,
  // and any stray lower bits are simply dropped
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      ptr_ff <= '0;
    else if (wr_stb_ff && wr_addr_ff == sri_pkg::OFF_READ_POINTER)
      ptr_ff <= wr_data_ff[sri_pkg::DATA_W-1 -: sri_pkg::REGNUM_W];
  end

  assign rif.wr_stb  = wr_stb_ff;
  assign rif.wr_addr = wr_addr_ff;
  assign rif.wr_data = wr_data_ff;
  assign rif.rd_addr = ptr_ff;

  // pulse n of 25..40 sends bit 40-n, msb first
  assign rd_bit = 4'(sri_pkg::RD_LAST - nxt_count);

  // readback pin updated on serial clock rise, zero outside the window
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      sdo_ff <= 1'b0;
    else if (sel_fall || sel_rise)
      sdo_ff <= 1'b0;  // idle low between frames
    else if (sclk_rise && state_ff == sri_pkg::SRI_SHIFT)
    begin
      if (nxt_count >= sri_pkg::RD_FIRST && nxt_count <= sri_pkg::RD_LAST)
        sdo_ff <= rif.rd_data[rd_bit];
      else
        sdo_ff <= 1'b0;
    end
  end

  assign serial_data_out = sdo_ff;

  // register array
  sri_regs u_regs (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .rif     (rif)
  );

  // control outputs are slices of the stored flops
  assign if_log_detector_on    = rif.words[sri_pkg::SL_EN][sri_pkg::B_LOGIF];
  assign diff_to_single_on     = rif.words[sri_pkg::SL_EN][sri_pkg::B_D2SE];
  assign common_mode_buf_on    = rif.words[sri_pkg::SL_EN][sri_pkg::B_CMBUF];
  assign log_detector_on       = rif.words[sri_pkg::SL_EN][sri_pkg::B_LOGD];
  assign square_detector_on    = rif.words[sri_pkg::SL_EN][sri_pkg::B_SQD];
  // inverted sense: a stored one turns the detector off
  assign envelope_detector_off = rif.words[sri_pkg::SL_EN][sri_pkg::B_ENVN];
  assign variable_gain_on      = rif.words[sri_pkg::SL_EN][sri_pkg::B_VGA];
  assign image_mixer_on        = rif.words[sri_pkg::SL_EN][sri_pkg::B_IRM];
  assign iq_lines_on           = rif.words[sri_pkg::SL_EN][sri_pkg::B_IQ];
  assign stepped_gain_on       = rif.words[sri_pkg::SL_EN][sri_pkg::B_DGA];
  assign lowpass_on            = rif.words[sri_pkg::SL_EN][sri_pkg::B_LPF];
  // diagnostics kept as written; software owns their values
  assign diag_bit10            = rif.words[sri_pkg::SL_EN][10];
  assign diag_bit8             = rif.words[sri_pkg::SL_EN][8];

  // gain word, zero is minimum
  assign stepped_gain_word =
    rif.words[sri_pkg::SL_GN][sri_pkg::GAIN_MSB:sri_pkg::GAIN_LSB];
  // bias fields
  assign amplifier_current =
    rif.words[sri_pkg::SL_AB][sri_pkg::CUR_MSB:sri_pkg::CUR_LSB];
  assign envelope_level    =
    rif.words[sri_pkg::SL_AB][sri_pkg::ENV_MSB:sri_pkg::ENV_LSB];
  assign attenuator_bias   =
    rif.words[sri_pkg::SL_AB][sri_pkg::ATT_MSB:sri_pkg::ATT_LSB];

  // sideband, one selects lower
  assign sideband_select   = rif.words[sri_pkg::SL_MI][sri_pkg::B_SIDEB];
  // offsets for I and Q
  assign i_offset_polarity = rif.words[sri_pkg::SL_MI][sri_pkg::B_OPOL];
  assign i_offset_value    =
    rif.words[sri_pkg::SL_MI][sri_pkg::OFS_MSB:sri_pkg::OFS_LSB];
  assign q_offset_polarity = rif.words[sri_pkg::SL_MQ][sri_pkg::B_OPOL];
  assign q_offset_value    =
    rif.words[sri_pkg::SL_MQ][sri_pkg::OFS_MSB:sri_pkg::OFS_LSB];
  // phase trims
  assign i_phase_trim      =
    rif.words[sri_pkg::SL_PI][sri_pkg::PH_MSB:sri_pkg::PH_LSB];
  assign q_phase_trim      =
    rif.words[sri_pkg::SL_PQ][sri_pkg::PH_MSB:sri_pkg::PH_LSB];

endmodule : sri_top

// ### sri_top_checker.sv
module sri_top_checker (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  // serial pins
  input  wire logic       serial_clk,
  input  wire logic       serial_select_n,
  input  wire logic       serial_data_out,
  // register outputs watched for loads
  input  wire logic       if_log_detector_on,
  input  wire logic       envelope_detector_off,
  input  wire logic [5:0] stepped_gain_word,
  input  wire logic       sideband_select,
  input  wire logic [8:0] q_phase_trim
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  logic        sclk_q_ff;   // raw serial clock, one cycle back
  logic        sel_q_ff;    // raw select, one cycle back
  logic [5:0]  pcnt_ff;     // clock rises in this frame
  logic [5:0]  hi_cnt_ff;   // cycles with select high, saturating
  logic [3:0]  evt_cnt_ff;  // cycles since a clock rise or select edge
  logic        good_wr_ff;  // last frame closed after exactly 24 rises
  logic        rise;        // raw clock rise seen this cycle
  logic [17:0] watch;       // outputs that only a load may move

  assign rise  = serial_clk & ~sclk_q_ff;
  assign watch = {if_log_detector_on, envelope_detector_off, stepped_gain_word,
                  sideband_select, q_phase_trim};

  // pin history; raw pins, so the design's sync lag shows in the windows
  always_ff @(posedge clk_sys or posedge sys_rst)
    if (sys_rst)
      {sclk_q_ff, sel_q_ff} <= 2'b01;
    else
      {sclk_q_ff, sel_q_ff} <= {serial_clk, serial_select_n};

  // pulse count, cleared while select is high
  always_ff @(posedge clk_sys or posedge sys_rst)
    if (sys_rst)
      pcnt_ff <= 6'h00;
    else
      pcnt_ff <= serial_select_n ? 6'h00 : pcnt_ff + 6'(rise);

  // time since select rose
  always_ff @(posedge clk_sys or posedge sys_rst)
    if (sys_rst)
      hi_cnt_ff <= 6'h00;
    else
      hi_cnt_ff <= !serial_select_n ? 6'h00 : hi_cnt_ff + 6'(hi_cnt_ff != 6'h3F);

  // time since the last event that may move the readback line
  always_ff @(posedge clk_sys or posedge sys_rst)
    if (sys_rst)
      evt_cnt_ff <= 4'hF;
    else
      evt_cnt_ff <= (rise | (serial_select_n ^ sel_q_ff)) ? 4'h0
                  : evt_cnt_ff + 4'(evt_cnt_ff != 4'hF);

  // frame length judged at the closing select rise
  always_ff @(posedge clk_sys or posedge sys_rst)
    if (sys_rst)
      good_wr_ff <= 1'b0;
    else if (serial_select_n & ~sel_q_ff)
      good_wr_ff <= (pcnt_ff == 6'h18);

  AST_LOAD_TIME: assert property ($changed(watch) |-> hi_cnt_ff inside {[6'd2:6'd10]})
    else $error("register output moved outside the load window");
  AST_LOAD_FULL: assert property ($changed(watch) |-> good_wr_ff)
    else $error("register output moved after a frame of wrong length");
  AST_FRAME_HOLD: assert property (!serial_select_n [*8] |-> $stable(watch))
    else $error("register output moved inside a frame");
  AST_SDO_IDLE: assert property (serial_select_n [*6] |-> !serial_data_out)
    else $error("readback line not low while deselected");
  AST_SDO_EDGE: assert property ($changed(serial_data_out) |-> evt_cnt_ff <= 4'd7)
    else $error("readback line moved away from a clock rise");
  AST_SDO_LEAD: assert property (!serial_select_n && pcnt_ff <= 6'd24 |-> !serial_data_out)
    else $error("readback bit driven during the first 24 pulses");
  AST_SDO_TAIL: assert property (pcnt_ff inside {[6'd42:6'd48]} |-> !serial_data_out)
    else $error("readback bit driven after the data window");
  AST_SDO_WINDOW: assert property ($rose(serial_data_out) |-> pcnt_ff inside {[6'd25:6'd41]})
    else $error("readback bit rose outside the data window");

  // main scenarios reached
  COV_LOAD: cover property (good_wr_ff && $changed(watch));
  COV_READ: cover property (pcnt_ff == 6'd48);
  COV_SDO:  cover property ($rose(serial_data_out));
endmodule : sri_top_checker

bind sri_top sri_top_checker chk_u (.clk_sys, .sys_rst, .serial_clk, .serial_select_n,
  .serial_data_out, .if_log_detector_on, .envelope_detector_off, .stepped_gain_word,
  .sideband_select, .q_phase_trim);

// ### sri_host_model.sv
module sri_host_model #(
  parameter logic [2:0] CHIP = 3'h0  // device address targeted
) (
  // system clock paces the serial clock
  input  wire logic clk_sys,
  // serial port, host side
  output logic      serial_clk,
  output logic      serial_select_n,
  output logic      serial_data_in,
  input  wire logic serial_data_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle: clock parked low, select high
  initial
  begin
    serial_clk      = 1'b0;
    serial_select_n = 1'b1;
    serial_data_in  = 1'b0;
  end

  // half period of 80 ns keeps the link well under its limit
  task automatic half();
    repeat (10) @(negedge clk_sys);
  endtask : half

  // one frame; readback taken late in the low phase after pulses 25..40
  task automatic frame(input logic [2:0] chip, input logic [4:0] rn,
                       input logic [15:0] d, input int pulses, output logic [15:0] q);
    logic [23:0] word;
    word = {chip, rn, d};  // address, number, data in order
    q = 16'h0000;
    serial_select_n = 1'b0;  // select low opens the frame
    for (int i = 0; i <= pulses; i++)
    begin
      serial_data_in = (i < 24) ? word[23-i] : ~serial_data_in;  // msb first
      half();
      if (i >= 25 && i <= 40)
        q[40-i] = serial_data_out;  // bit of the previous pulse
      if (i < pulses)
        serial_clk = 1'b1;  // data taken on this rise
      half();
      serial_clk = 1'b0;
    end
    serial_select_n = 1'b1;  // select rise loads the word
    serial_data_in = ~serial_data_in;  // released line shows no stale bit
    half();
  endtask : frame

  // write one whole register in 24 pulses
  task automatic wr(input logic [4:0] rn, input logic [15:0] d);
    logic [15:0] unused;
    frame(CHIP, rn, d, 24, unused);  // full write frame
  endtask : wr

  // pointer write with a zero tail, then the long read frame
  task automatic rd(input logic [4:0] rn, output logic [15:0] q);
    logic [15:0] unused;
    frame(CHIP, 5'h07, {rn, 11'h000}, 24, unused);  // pointer first
    frame(CHIP, 5'h00, 16'h0000, 48, q);  // 48-pulse read
  endtask : rd
endmodule : sri_host_model

// ### testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [2:0] CHIP = 3'h2;  // arbitrary device address
  // per slot: register number, reset word, test word
  localparam logic [4:0] REGN [7] = '{5'h01, 5'h03, 5'h04, 5'h05, 5'h06, 5'h08, 5'h09};
  localparam logic [15:0] RSTW [7] = '{16'hD9FA, 16'h0000, 16'h0FF2, 16'h2A00,
                                      16'hF000, 16'hF000, 16'hF000};
  localparam logic [15:0] WRW [7] = '{16'h2305, 16'h4600, 16'hF00D, 16'h23A5,
                                     16'h015A, 16'h01C3, 16'h003C};

  logic        clk_sys;
  logic        sys_rst;
  logic        serial_clk;
  logic        serial_select_n;
  logic        serial_data_in;
  logic        serial_data_out;
  wire  [64:0] pins;        // every field output, enables first
  logic [15:0] ew [7];      // expected stored word per slot
  int          err_count = 0;
  int          num_checks = 0;
  int          cyc = 0;     // cycles run, for the hang limit

  sri_top #(.CHIP_ADDR(CHIP)) dut_u (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .serial_clk(serial_clk),
    .serial_select_n(serial_select_n), .serial_data_in(serial_data_in),
    .serial_data_out(serial_data_out), .if_log_detector_on(pins[64]),
    .diff_to_single_on(pins[63]), .common_mode_buf_on(pins[62]), .log_detector_on(pins[61]),
    .square_detector_on(pins[60]), .envelope_detector_off(pins[59]),
    .variable_gain_on(pins[58]), .image_mixer_on(pins[57]), .iq_lines_on(pins[56]),
    .stepped_gain_on(pins[55]), .lowpass_on(pins[54]), .diag_bit10(pins[53]),
    .diag_bit8(pins[52]), .stepped_gain_word(pins[51:46]), .amplifier_current(pins[45:44]),
    .envelope_level(pins[43:39]), .attenuator_bias(pins[38:37]), .sideband_select(pins[36]),
    .i_offset_polarity(pins[35]), .i_offset_value(pins[34:27]), .q_offset_polarity(pins[26]),
    .q_offset_value(pins[25:18]), .i_phase_trim(pins[17:9]), .q_phase_trim(pins[8:0]));

  sri_host_model #(.CHIP(CHIP)) hm_u (
    .clk_sys(clk_sys), .serial_clk(serial_clk), .serial_select_n(serial_select_n),
    .serial_data_in(serial_data_in), .serial_data_out(serial_data_out));

  // 125 MHz system clock
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // hang limit, about twice the expected run
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 80000)
    begin
      err_count++;
      tally_and_finish();
    end
  end

  // pins the stored words should produce
  function automatic logic [64:0] exp_pins();
    return {ew[0][12], ew[0][11], ew[0][9], ew[0][7:0], ew[0][10], ew[0][8], ew[1][14:9],
            ew[2][8:0], ew[3][11], ew[3][8:0], ew[4][8:0], ew[5][8:0], ew[6][8:0]};
  endfunction : exp_pins

  task automatic cmp_w(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_w

  task automatic cmp_p(input logic [64:0] exp, input logic [64:0] got);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR pins expected %h seen %h", exp, got);
    end
  endtask : cmp_p

  // every slot back through pointer and long frame
  task automatic read_all();
    logic [15:0] q;
    for (int i = 0; i < 7; i++)
    begin
      hm_u.rd(REGN[i], q);
      cmp_w("readback", ew[i], q);  // word returned msb first
    end
  endtask : read_all

  // reset words at the pins and through readback, unmapped numbers too
  task automatic t_reset();
    logic [15:0] q;
    ew = RSTW;
    cmp_p(exp_pins(), pins);  // reset fields
    read_all();  // all words reset
    hm_u.rd(5'h02, q);
    cmp_w("unmapped", 16'h0000, q);  // no word at this number
    hm_u.rd(5'h07, q);
    cmp_w("pointer", 16'h0000, q);  // pointer itself reads zero
  endtask : t_reset

  // each register written in turn; only the addressed word may move
  task automatic t_write();
    for (int i = 0; i < 7; i++)
    begin
      hm_u.wr(REGN[i], WRW[i]);  // diagnostic bits kept normal
      ew[i] = WRW[i];
      cmp_p(exp_pins(), pins);  // whole word, right place
    end
    read_all();  // written words return
  endtask : t_write

  // short, long and foreign frames leave words alone; then gain back to minimum
  task automatic t_refuse();
    logic [15:0] q;
    hm_u.frame(CHIP, 5'h03, 16'h1200, 23, q);
    hm_u.frame(3'h1, 5'h03, 16'h1200, 25, q);  // last 24 bits match our chip
    hm_u.frame(3'h5, 5'h03, 16'h1200, 24, q);
    cmp_p(exp_pins(), pins);  // nothing loaded
    hm_u.wr(5'h03, 16'h0000);
    ew[1] = 16'h0000;
    cmp_p(exp_pins(), pins);  // gain word at minimum
  endtask : t_refuse

  // a second reset mid-run restores every reset word
  task automatic t_rerst();
    sys_rst = 1'b1;
    repeat (3) @(negedge clk_sys);
    sys_rst = 1'b0;
    repeat (5) @(negedge clk_sys);
    ew = RSTW;
    cmp_p(exp_pins(), pins);  // envelope off again
    read_all();  // words restored
  endtask : t_rerst

  task automatic tally_and_finish();
    if (err_count == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish

  // main sequence
  initial
  begin
    sys_rst = 1'b1;
    repeat (12) @(posedge clk_sys);
    @(negedge clk_sys);
    sys_rst = 1'b0;
    repeat (5) @(negedge clk_sys);
    t_reset();
    t_write();
    t_refuse();
    t_rerst();
    tally_and_finish();
  end
endmodule : testbench
